// file: aam_pkg.sv
package aam_pkg;

    localparam int CLK_HZ = 40_000_000;
    localparam int HZ_PER_KHZ = 1000;
    localparam int CYCLES_PER_MS = CLK_HZ / HZ_PER_KHZ;

    // activation budgets, in milliseconds, the cold one first given in seconds
    localparam int RESUME_LIMIT_MS = 300;
    localparam int REGEN_LIMIT_MS = 600;
    localparam int COLD_LIMIT_S = 10;
    localparam int MS_PER_S = 1000;
    localparam int COLD_LIMIT_MS = COLD_LIMIT_S * MS_PER_S;

    // late activations may not exceed one in twenty
    localparam int LATE_RATIO = 20;

    localparam int MS_W = 14;
    localparam int CNT_W = 16;

    // loopback selectors
    localparam logic [1:0] LOOP_LT = 2'h0;
    localparam logic [1:0] LOOP_REGEN = 2'h1;
    localparam logic [1:0] LOOP_NT = 2'h2;

    // status units
    localparam logic [1:0] UNIT_LT = 2'h0;
    localparam logic [1:0] UNIT_REGEN = 2'h1;
    localparam logic [1:0] UNIT_NT = 2'h2;

    // defect bit positions
    localparam int DEF_ERR_RATE = 0;
    localparam int DEF_LOS = 1;
    localparam int DEF_LOF = 2;
    localparam int DEF_PWR = 3;
    localparam int DEF_W = 4;

    // pin vector layout ahead of the synchroniser
    localparam int PIN_WAKE = 0;
    localparam int PIN_SYNC = 1;
    localparam int PIN_REGEN = 2;
    localparam int PIN_DEF = 3;
    localparam int PIN_W = PIN_DEF + DEF_W;

    typedef enum logic [2:0] {
        AAM_DEACT = 3'h0,
        AAM_ACTING = 3'h1,
        AAM_ACTIVE = 3'h2,
        AAM_LOOPING = 3'h3,
        AAM_LOOPED = 3'h4
    } aam_state_t;

    typedef struct packed {
        logic valid;
        logic [1:0] sel;
    } aam_loop_cmd_t;

    typedef struct packed {
        logic valid;
        logic [1:0] unit;
    } aam_status_req_t;

    typedef struct packed {
        logic valid;
        logic on;
    } aam_power_cmd_t;

    typedef struct packed {
        logic valid;
        logic [1:0] unit;
        logic [7:0] data;
    } aam_status_rsp_t;

    typedef struct packed {
        logic valid;
        logic [DEF_W-1:0] defects;
    } aam_defect_info_t;

endpackage : aam_pkg

// file: aam_access_maint.sv
module aam_access_maint #(
    parameter int CyclesPerMs = aam_pkg::CYCLES_PER_MS,
    parameter int ResumeLimitMs = aam_pkg::RESUME_LIMIT_MS,
    parameter int RegenLimitMs = aam_pkg::REGEN_LIMIT_MS,
    parameter int ColdLimitMs = aam_pkg::COLD_LIMIT_MS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic activateFunctionElement,
    input wire logic deactivateReq,
    input wire logic userWakeupPin,
    input wire logic lineSyncPin,
    input wire logic regenPresentPin,
    input wire logic [aam_pkg::DEF_W-1:0] defectPins,
    input wire aam_pkg::aam_loop_cmd_t loopCmd,
    input wire logic loopRelease,
    input wire aam_pkg::aam_status_req_t statusReq,
    input wire aam_pkg::aam_power_cmd_t powerCmd,
    input wire logic autoPowerOff,
    output logic activatedFunctionElement,
    output logic networkActiveSignal,
    output logic deactivatedIndication,
    output logic loopActive,
    output logic [1:0] loopSel,
    output logic layer2Suppress,
    output logic powerFeedOn,
    output aam_pkg::aam_defect_info_t defectIndicationInfo,
    output aam_pkg::aam_status_rsp_t statusRsp,
    output logic activationLate,
    output logic lateShareExceeded,
    output logic [aam_pkg::MS_W-1:0] lastIntervalMs
);

    localparam int MS_MAX = (1 << aam_pkg::MS_W) - 1;
    generate
        if (CyclesPerMs < 1 || ResumeLimitMs < 1 || RegenLimitMs < 1 || ColdLimitMs < 1
            || ColdLimitMs > MS_MAX || RegenLimitMs > MS_MAX) begin : gBadParam
            $error("aam_access_maint: timing parameter out of range");
        end
    endgenerate
    // status payload per addressed unit
    function automatic logic [7:0] statusData(
        input logic [1:0] unit,
        input logic looping,
        input logic [1:0] sel,
        input logic [aam_pkg::DEF_W-1:0] defects,
        input logic power
    );
        logic hit;
        hit = 1'b0;
        case (unit)
            aam_pkg::UNIT_LT: hit = looping && sel == aam_pkg::LOOP_LT;
            aam_pkg::UNIT_REGEN: hit = looping && sel == aam_pkg::LOOP_REGEN;
            default: hit = looping && sel == aam_pkg::LOOP_NT;
        endcase
        statusData = {2'h0, power, hit, defects};
    endfunction : statusData
    // two-flop synchroniser for all pin inputs
    logic [aam_pkg::PIN_W-1:0] pinMeta_reg;
    logic [aam_pkg::PIN_W-1:0] pinSync_reg;
    logic [aam_pkg::PIN_W-1:0] pinPrev_reg;
    always_ff @(posedge clk) begin
        if (srst) begin
            pinMeta_reg <= '0;
            pinSync_reg <= '0;
            pinPrev_reg <= '0;
        end else begin
            pinMeta_reg <= {defectPins, regenPresentPin, lineSyncPin, userWakeupPin};
            pinSync_reg <= pinMeta_reg;
            pinPrev_reg <= pinSync_reg;
        end
    end
    logic wakeRise;
    logic lineSync;
    logic regenPresent;
    logic [aam_pkg::DEF_W-1:0] defects;
    logic [aam_pkg::DEF_W-1:0] defectRise;
    assign wakeRise = pinSync_reg[aam_pkg::PIN_WAKE] && !pinPrev_reg[aam_pkg::PIN_WAKE];
    assign lineSync = pinSync_reg[aam_pkg::PIN_SYNC];
    assign regenPresent = pinSync_reg[aam_pkg::PIN_REGEN];
    assign defects = pinSync_reg[aam_pkg::PIN_DEF +: aam_pkg::DEF_W];
    assign defectRise = defects & ~pinPrev_reg[aam_pkg::PIN_DEF +: aam_pkg::DEF_W];
    // millisecond tick
    logic [31:0] tickCnt_reg;
    logic msTick;
    assign msTick = tickCnt_reg == 32'(CyclesPerMs - 1);
    always_ff @(posedge clk) begin
        if (srst || msTick) begin
            tickCnt_reg <= '0;
        end else begin
            tickCnt_reg <= tickCnt_reg + 32'h1;
        end
    end
    aam_pkg::aam_state_t state_reg;
    aam_pkg::aam_state_t state_next;
    logic powerOn_reg;
    logic powerOffNow;
    logic startAct;
    logic loopAccept;
    logic lineUp;
    assign powerOffNow = (powerCmd.valid && !powerCmd.on)
        || (autoPowerOff && defectRise[aam_pkg::DEF_PWR]);
    assign startAct = state_reg == aam_pkg::AAM_DEACT && powerOn_reg
        && (activateFunctionElement || wakeRise);
    assign loopAccept = state_reg == aam_pkg::AAM_DEACT && powerOn_reg
        && loopCmd.valid && loopCmd.sel <= aam_pkg::LOOP_NT;
    assign lineUp = lineSync && powerOn_reg;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            aam_pkg::AAM_DEACT: begin
                // loopback wins a tie with a call activation
                if (loopAccept) begin
                    state_next = aam_pkg::AAM_LOOPING;
                end else if (startAct) begin
                    state_next = aam_pkg::AAM_ACTING;
                end
            end
            aam_pkg::AAM_ACTING: begin
                if (deactivateReq) begin
                    state_next = aam_pkg::AAM_DEACT;
                end else if (lineUp) begin
                    state_next = aam_pkg::AAM_ACTIVE;
                end
            end
            aam_pkg::AAM_ACTIVE: begin
                if (deactivateReq || !lineSync) begin
                    state_next = aam_pkg::AAM_DEACT;
                end
            end
            aam_pkg::AAM_LOOPING: begin
                // activation requests are not looked at here
                if (loopRelease) begin
                    state_next = aam_pkg::AAM_DEACT;
                end else if (lineUp) begin
                    state_next = aam_pkg::AAM_LOOPED;
                end
            end
            aam_pkg::AAM_LOOPED: begin
                if (loopRelease) begin
                    state_next = aam_pkg::AAM_DEACT;
                end
            end
            default: state_next = aam_pkg::AAM_DEACT;
        endcase
        if (powerOffNow) begin
            state_next = aam_pkg::AAM_DEACT;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= aam_pkg::AAM_DEACT;
        end else begin
            state_reg <= state_next;
        end
    end

    logic enterActive;
    logic leaveUp;
    assign enterActive = state_next != state_reg && (state_next == aam_pkg::AAM_ACTIVE
        || state_next == aam_pkg::AAM_LOOPED);
    assign leaveUp = state_next == aam_pkg::AAM_DEACT && state_reg != aam_pkg::AAM_DEACT;

    // indications toward the exchange side
    always_ff @(posedge clk) begin
        if (srst) begin
            activatedFunctionElement <= 1'b0;
            deactivatedIndication <= 1'b0;
            networkActiveSignal <= 1'b0;
            loopActive <= 1'b0;
            loopSel <= aam_pkg::LOOP_LT;
            layer2Suppress <= 1'b0;
        end else begin
            activatedFunctionElement <= enterActive;
            deactivatedIndication <= leaveUp;
            networkActiveSignal <= state_next == aam_pkg::AAM_ACTIVE
                || state_next == aam_pkg::AAM_LOOPED;
            loopActive <= state_next == aam_pkg::AAM_LOOPING
                || state_next == aam_pkg::AAM_LOOPED;
            layer2Suppress <= state_next == aam_pkg::AAM_LOOPING
                || state_next == aam_pkg::AAM_LOOPED;
            if (loopAccept) begin
                loopSel <= loopCmd.sel;
            end
        end
    end

    // power feed, and the cold-start marker it drives
    logic cold_reg;
    always_ff @(posedge clk) begin
        if (srst) begin
            powerOn_reg <= 1'b1;
            cold_reg <= 1'b1;
        end else begin
            if (powerOffNow) begin
                powerOn_reg <= 1'b0;
            end else if (powerCmd.valid && powerCmd.on) begin
                powerOn_reg <= 1'b1;
            end
            if (powerCmd.valid && powerCmd.on && !powerOn_reg) begin
                cold_reg <= 1'b1;
            end else if (enterActive) begin
                cold_reg <= 1'b0;
            end
        end
    end

    assign powerFeedOn = powerOn_reg;
    // activation interval, saturating in milliseconds
    logic [aam_pkg::MS_W-1:0] elapsed_reg;
    logic [aam_pkg::MS_W-1:0] limitMs;
    assign limitMs = cold_reg ? aam_pkg::MS_W'(ColdLimitMs)
        : regenPresent ? aam_pkg::MS_W'(RegenLimitMs) : aam_pkg::MS_W'(ResumeLimitMs);

    always_ff @(posedge clk) begin
        if (srst || startAct || loopAccept) begin
            elapsed_reg <= '0;
        end else if (msTick && elapsed_reg != aam_pkg::MS_W'(MS_MAX)) begin
            elapsed_reg <= elapsed_reg + aam_pkg::MS_W'(1);
        end
    end

    // late share over all activations, one late in twenty tolerated
    logic [aam_pkg::CNT_W-1:0] totalCnt_reg;
    logic [aam_pkg::CNT_W-1:0] lateCnt_reg;
    logic isLate;
    logic [aam_pkg::CNT_W+4:0] lateScaled;
    assign isLate = elapsed_reg >= limitMs;
    assign lateScaled = (aam_pkg::CNT_W+5)'(lateCnt_reg) * (aam_pkg::CNT_W+5)'(aam_pkg::LATE_RATIO);

    always_ff @(posedge clk) begin
        if (srst) begin
            totalCnt_reg <= '0;
            lateCnt_reg <= '0;
            activationLate <= 1'b0;
            lateShareExceeded <= 1'b0;
            lastIntervalMs <= '0;
        end else begin
            activationLate <= enterActive && isLate;
            if (enterActive && totalCnt_reg != '1) begin
                totalCnt_reg <= totalCnt_reg + aam_pkg::CNT_W'(1);
                lastIntervalMs <= elapsed_reg;
                if (isLate) begin
                    lateCnt_reg <= lateCnt_reg + aam_pkg::CNT_W'(1);
                end
            end
            lateShareExceeded <= lateScaled > (aam_pkg::CNT_W+5)'(totalCnt_reg);
        end
    end

    // unprompted defect report on any newly raised defect
    always_ff @(posedge clk) begin
        if (srst) begin
            defectIndicationInfo <= '0;
        end else begin
            defectIndicationInfo.valid <= |defectRise;
            defectIndicationInfo.defects <= defects;
        end
    end

    // every status request gets exactly one answer
    always_ff @(posedge clk) begin
        if (srst) begin
            statusRsp <= '0;
        end else begin
            statusRsp.valid <= statusReq.valid;
            if (statusReq.valid) begin
                statusRsp.unit <= statusReq.unit;
                statusRsp.data <= statusData(statusReq.unit, loopActive, loopSel,
                    defects, powerOn_reg);
            end
        end
    end

endmodule : aam_access_maint

// file: aam_checker_monitor.sv
module aam_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic activateFunctionElement,
    input wire logic [aam_pkg::DEF_W-1:0] defectPins,
    input wire aam_pkg::aam_loop_cmd_t loopCmd,
    input wire aam_pkg::aam_status_req_t statusReq,
    input wire aam_pkg::aam_power_cmd_t powerCmd,
    input wire logic activatedFunctionElement,
    input wire logic networkActiveSignal,
    input wire logic loopActive,
    input wire logic [1:0] loopSel,
    input wire logic layer2Suppress,
    input wire logic powerFeedOn,
    input wire aam_pkg::aam_defect_info_t defectIndicationInfo,
    input wire aam_pkg::aam_status_rsp_t statusRsp,
    input wire logic activationLate
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    suppress_match_a: assert property (layer2Suppress == loopActive)
        else $error("layer 2 suppression differs from loopback state");
    status_answer_a: assert property (statusReq.valid && statusReq.unit != 2'h3 |=>
        statusRsp.valid && statusRsp.unit == $past(statusReq.unit))
        else $error("status request not answered next cycle");
    loop_wins_a: assert property (loopActive && activateFunctionElement |=> loopActive)
        else $error("activation request overrode loopback");
    loop_locked_a: assert property (loopActive && loopCmd.valid |=> $stable(loopSel))
        else $error("loopback selector changed during loopback");
    loop_refused_a: assert property (networkActiveSignal && !loopActive && loopCmd.valid
        |=> !loopActive)
        else $error("loopback accepted outside deactivated state");
    power_off_a: assert property (powerCmd.valid && !powerCmd.on |=>
        !powerFeedOn && !networkActiveSignal && !loopActive)
        else $error("power off did not drop feed and section");
    power_on_a: assert property (powerCmd.valid && powerCmd.on |=> powerFeedOn)
        else $error("power on did not raise feed");
    defect_report_a: assert property (|(defectPins & ~$past(defectPins)) |->
        ##[2:5] defectIndicationInfo.valid)
        else $error("defect not reported unprompted");
    act_pulse_a: assert property (activatedFunctionElement |->
        networkActiveSignal ##1 !activatedFunctionElement)
        else $error("activated element not a single pulse with active level");
    late_with_act_a: assert property (activationLate |-> activatedFunctionElement)
        else $error("late flag without activation");

    cover property (activatedFunctionElement && loopActive);
    cover property (activationLate);
    cover property (defectIndicationInfo.valid && !powerFeedOn);
endmodule : aam_checker

bind aam_access_maint aam_checker i_chk (.*);

// file: aam_line_model.sv
// digital section far end: line reaches sync a set number of cycles after a start
module aam_line_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic stop,
    input wire logic feedOn,
    input wire logic [7:0] delayCyc,
    output logic lineSync
);
    logic [7:0] cnt_reg;
    logic busy_reg;

    always_ff @(posedge clk) begin
        // without feed the remote end is dead, so the line drops at once
        if (srst || stop || !feedOn) begin
            busy_reg <= 1'b0;
            lineSync <= 1'b0;
            cnt_reg <= 8'h0;
        end else if (start && !busy_reg && !lineSync) begin
            busy_reg <= 1'b1;
            cnt_reg <= 8'h0;
        end else if (busy_reg) begin
            if (cnt_reg == delayCyc) begin
                lineSync <= 1'b1;
                busy_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg + 8'h1;
            end
        end
    end
endmodule : aam_line_model

// file: aam_testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [15:0] v; logic [15:0] m;} aam_tb_exp_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic activateFunctionElement, deactivateReq, userWakeupPin, lineSyncPin;
    logic regenPresentPin, loopRelease, autoPowerOff;
    logic [aam_pkg::DEF_W-1:0] defectPins;
    aam_pkg::aam_loop_cmd_t loopCmd;
    aam_pkg::aam_status_req_t statusReq;
    aam_pkg::aam_power_cmd_t powerCmd;
    logic activatedFunctionElement, networkActiveSignal, deactivatedIndication;
    logic loopActive, layer2Suppress, powerFeedOn, activationLate, lateShareExceeded;
    logic [1:0] loopSel;
    aam_pkg::aam_defect_info_t defectIndicationInfo;
    aam_pkg::aam_status_rsp_t statusRsp;
    logic [aam_pkg::MS_W-1:0] lastIntervalMs;
    logic [7:0] delayCyc;
    logic [31:0] seed = 32'h48;
    logic [3:0] pat;
    logic [1:0] u;
    aam_tb_exp_t expq[4][$];
    int n_fail = 0;
    int compares = 0;
    // exchange supervision timer, stretched well past the slowest limit in use
    localparam int SupervisionCyc = 400;

    always #12.5 clk = ~clk;

    // limits shrunk so a millisecond is four cycles
    aam_access_maint #(.CyclesPerMs(4), .ResumeLimitMs(5), .RegenLimitMs(10),
        .ColdLimitMs(20)) i_dut (.*);
    aam_line_model i_line (.clk(clk), .srst(srst),
        .start(activateFunctionElement || userWakeupPin || (loopCmd.valid && loopCmd.sel != 2'h3)),
        .stop(deactivateReq || loopRelease), .feedOn(powerFeedOn),
        .delayCyc(delayCyc), .lineSync(lineSyncPin));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    task automatic cmp(input string name, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : cmp

    task automatic take(input int k, input logic [15:0] got);
        aam_tb_exp_t e;
        // an unannounced result is a fault in its own right
        if (expq[k].size() == 0) begin
            n_fail++;
            $display("Error result kind %0d expected none seen %h", k, got);
        end else begin
            e = expq[k].pop_front();
            cmp($sformatf("result kind %0d", k), e.v & e.m, got & e.m);
        end
    endtask : take

    // results may land in the same cycle, so each kind keeps its own queue
    always @(negedge clk) begin
        if (!srst) begin
            if (activatedFunctionElement) take(0, {15'h0, activationLate});
            if (deactivatedIndication) take(1, 16'h0);
            if (defectIndicationInfo.valid) take(2, {12'h0, defectIndicationInfo.defects});
            if (statusRsp.valid) take(3, {6'h0, statusRsp.unit, statusRsp.data});
        end
    end

    task automatic drain(input int bound);
        for (int i = 0; i < bound; i++) begin
            if (expq[0].size() + expq[1].size() + expq[2].size() + expq[3].size() == 0) return;
            @(posedge clk);
        end
        n_fail++;
        $display("Error wait for results expected none pending seen some");
        end_of_test();
    endtask : drain

    task automatic settle();
        @(posedge clk);
        #1;
    endtask : settle

    task automatic activate(input logic [7:0] d, input logic [15:0] v, input logic [15:0] m);
        expq[0].push_back('{v, m});
        @(posedge clk);
        delayCyc <= d;
        activateFunctionElement <= 1'b1;
        @(posedge clk);
        activateFunctionElement <= 1'b0;
        // supervision expiry counts as a failed continuity test
        drain(SupervisionCyc);
    endtask : activate

    task automatic deactivate();
        expq[1].push_back('{16'h0, 16'hffff});
        @(posedge clk);
        deactivateReq <= 1'b1;
        @(posedge clk);
        deactivateReq <= 1'b0;
        drain(50);
    endtask : deactivate

    task automatic status(input logic [1:0] un, input logic [7:0] d);
        expq[3].push_back('{{6'h0, un, d}, 16'hffff});
        @(posedge clk);
        statusReq <= '{1'b1, un};
        @(posedge clk);
        statusReq <= '0;
        drain(20);
    endtask : status

    task automatic loop_cmd(input logic [1:0] s, input logic act);
        @(posedge clk);
        loopCmd <= '{1'b1, s};
        activateFunctionElement <= act;
        @(posedge clk);
        loopCmd <= '0;
        activateFunctionElement <= 1'b0;
        settle();
    endtask : loop_cmd

    task automatic power(input logic on);
        @(posedge clk);
        powerCmd <= '{1'b1, on};
        @(posedge clk);
        powerCmd <= '0;
        settle();
        cmp("power feed", {15'h0, on}, {15'h0, powerFeedOn});
    endtask : power

    initial begin
        {activateFunctionElement, deactivateReq, userWakeupPin} = '0;
        {regenPresentPin, loopRelease, autoPowerOff} = '0;
        defectPins = '0;
        loopCmd = '0;
        statusReq = '0;
        powerCmd = '0;
        delayCyc = 8'h28;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        activate(8'h28, 16'h0, 16'h1);
        loop_cmd(2'h0, 1'b0);
        cmp("loop while active", 16'h0, {15'h0, loopActive});
        deactivate();
        cmp("late share", 16'h0, {15'h0, lateShareExceeded});
        activate(8'h28, 16'h1, 16'h1);
        deactivate();
        cmp("late share", 16'h1, {15'h0, lateShareExceeded});
        // 40 model cycles plus pin latency at four cycles a millisecond
        cmp("last interval", 16'h1, {15'h0, lastIntervalMs inside {14'ha, 14'hb}});
        regenPresentPin <= 1'b1;
        repeat (4) @(posedge clk);
        activate(8'h14, 16'h0, 16'h1);
        deactivate();
        expq[0].push_back('{16'h0, 16'h1});
        @(posedge clk);
        userWakeupPin <= 1'b1;
        drain(SupervisionCyc);
        userWakeupPin <= 1'b0;
        deactivate();
        $display("test activation limits done");
        for (int s = 0; s < 3; s++) begin
            expq[0].push_back('{16'h0, 16'h1});
            loop_cmd(s[1:0], 1'b1);
            cmp("loop active", 16'h1, {15'h0, loopActive});
            cmp("loop select", 16'(s), {14'h0, loopSel});
            loop_cmd(2'(s + 1), 1'b1);
            drain(SupervisionCyc);
            status(s[1:0], 8'h30);
            status(2'((s + 1) % 3), 8'h20);
            expq[1].push_back('{16'h0, 16'hffff});
            @(posedge clk);
            loopRelease <= 1'b1;
            @(posedge clk);
            loopRelease <= 1'b0;
            drain(50);
        end
        loop_cmd(2'h3, 1'b0);
        cmp("reserved loop", 16'h0, {15'h0, loopActive});
        $display("test loopbacks done");
        activate(8'h08, 16'h0, 16'h1);
        pat = 4'(xs()) | 4'h8;
        expq[2].push_back('{{12'h0, pat}, 16'hffff});
        expq[1].push_back('{16'h0, 16'hffff});
        @(posedge clk);
        autoPowerOff <= 1'b1;
        defectPins <= pat;
        drain(50);
        cmp("auto power off", 16'h0, {15'h0, powerFeedOn});
        u = 2'(xs() % 3);
        status(u, {4'h0, pat});
        power(1'b1);
        power(1'b0);
        power(1'b1);
        $display("test defects and power done");
        end_of_test();
    end
endmodule : testbench
